// file: verilog/pcs_ctl_pkg.sv
// package: register map, field positions, reset values and types for the pcs control block
package pcs_ctl_pkg;
  localparam logic [15:0] off_configuration = 16'h4200;
  localparam logic [15:0] off_link_control = 16'h4208;
  localparam logic [15:0] off_link_status = 16'h420c;
  localparam logic [15:0] off_advertisement = 16'h4218;
  localparam logic [15:0] off_partner_ability = 16'h421c;
  // configuration fields
  localparam int cfg_enable_bit = 3;
  localparam int cfg_isolate_bit = 30;
  localparam int cfg_soft_reset_bit = 31;
  // link control fields
  localparam int lc_forced_link_bit = 0;
  localparam int lc_speed_lo = 1;
  localparam int lc_duplex_bit = 3;
  localparam int lc_force_sd_bit = 4;
  localparam int lc_force_link_bit = 5;
  localparam int lc_latch_bit = 6;
  localparam int lc_force_fc_bit = 7;
  localparam int lc_negotiation_enable_bit = 16;
  localparam int lc_restart_bit = 17;
  localparam int lc_timeout_en_bit = 18;
  localparam int lc_bypass_bit = 19;
  localparam int lc_trigger_bit = 20;
  localparam int lc_fast_timer_bit = 24;
  localparam int lc_fix_en_bit = 25;
  // link status fields
  localparam int st_sync_bit = 4;
  localparam int st_complete_bit = 16;
  localparam int st_page_bit = 17;
  localparam int st_timedout_bit = 18;
  localparam int st_fault_bit = 19;
  localparam int st_error_bit = 20;
  // advertisement / partner fields
  localparam int adv_fd_bit = 5;
  localparam int adv_hd_bit = 6;
  localparam int adv_pause_lo = 7;
  localparam int adv_fault_lo = 12;
  localparam int adv_np_bit = 15;
  localparam int lp_ack_bit = 14;
  localparam int lp_sgmii_speed_lo = 10;
  localparam int lp_sgmii_duplex_bit = 12;
  localparam int lp_sgmii_link_bit = 15;
  // reset values
  localparam logic [1:0] rst_forced_speed = 2'h2;
  localparam logic [1:0] speed_1000 = 2'h2;
  // keeps serializer and sgmii partner fields, read path masks per mode
  localparam logic [15:0] page_mask = 16'hfde0;
  localparam logic [31:0] rst_configuration = 32'h0000_0008;
  localparam logic [31:0] rst_link_control = 32'h0204_000c;
  localparam logic [31:0] rst_advertisement = 32'h0000_0020;
  localparam logic [31:0] cfg_write_mask = 32'hc000_0008;
  localparam logic [31:0] lc_write_mask = 32'h031f_00ff;
  localparam logic [31:0] adv_write_mask = 32'h0000_b1a0;
  // negotiation timer, cycles at 200 MHz
  localparam int link_timer_us = 10;
  localparam int clk_mhz = 200;
  localparam int link_timer_cycles = link_timer_us * clk_mhz;
  localparam int fast_timer_cycles = 64;
  localparam int timeout_pages_cycles = 4 * link_timer_cycles;

  typedef enum logic [2:0] {an_disabled, an_restart, an_ability, an_ack, an_idle_detect, an_link_ok} an_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } page_type;
endpackage

// file: verilog/pcs_reg_slice.sv
// module: one masked software register with hardware self-clear bits
module pcs_reg_slice #(
  parameter logic [31:0] reset_value = 32'h0000_0000,
  parameter logic [31:0] write_mask = 32'hffff_ffff
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  input wire logic [31:0] hw_clear,
  output logic [31:0] value
);
  logic [31:0] value_ff;
  logic [31:0] nxt_value;

  always_comb begin
    nxt_value = value_ff & ~hw_clear;
    if (wr_en) begin
      nxt_value = (wdata & write_mask) | (value_ff & ~write_mask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      value_ff <= reset_value;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;
endmodule

// file: verilog/pcs_page_rx.sv
// module: base page capture from the partner, needs two equal words before acceptance
module pcs_page_rx (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic word_valid,
  input wire logic [15:0] word,
  output pcs_ctl_pkg::page_type page
);
  logic [15:0] last_ff;
  logic seen_ff;
  pcs_ctl_pkg::page_type page_ff;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      last_ff <= 16'h0000;
      seen_ff <= 1'b0;
      page_ff <= '0;
    end else begin
      page_ff.valid <= 1'b0;
      if (word_valid) begin
        last_ff <= word;
        seen_ff <= 1'b1;
        // matching repeat filters single corrupted words
        if (seen_ff && last_ff == word) begin
          page_ff.valid <= 1'b1;
          page_ff.word <= word;
        end
      end
    end
  end

  assign page = page_ff;
endmodule

// file: verilog/pcs_link_autoneg_control.sv
// module: pcs enable, link forcing, negotiation control and status registers
module pcs_link_autoneg_control (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sgmii_mode,
  input wire logic sync_ok_in,
  input wire logic idle_ok_in,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic pause_transmit_enable,
  input wire logic pause_receive_enable,
  output logic [15:0] tx_config_word,
  output logic tx_config_send,
  output logic pcs_tx_enable,
  output logic pcs_rx_enable,
  output logic mac_path_enable,
  output logic soft_reset_ctl,
  output logic link_ok,
  output logic [1:0] link_speed,
  output logic link_duplex,
  output logic pause_tx_active,
  output logic pause_rx_active
);
  //////////////////////////////////////////////////////////////////////////////
  pcs_ctl_pkg::reg_req_type req;
  logic [31:0] cfg;
  logic [31:0] lc;
  logic [31:0] adv;
  logic [31:0] lc_clear;
  logic sync_s1_ff, sync_s2_ff, idle_s1_ff, idle_s2_ff;
  logic sync_prev_ff;
  pcs_ctl_pkg::page_type page;
  logic [15:0] partner_ff;
  pcs_ctl_pkg::an_state_type state_ff;
  logic [31:0] timer_ff;
  logic [31:0] page_wait_ff;
  logic restart_req;
  logic an_link_ok;
  logic link_var;
  logic link_var_prev_ff;
  logic latched_low_ff;
  logic complete_ff, page_flag_ff, timedout_ff, fault_flag_ff, error_ff;
  logic [31:0] rdata_ff;
  logic [31:0] timer_limit;
  logic [1:0] an_speed;
  logic an_duplex;
  logic an_start;
  logic rd_status;
  logic wr_status;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  assign rd_status = req.rd && hit(req.addr, pcs_ctl_pkg::off_link_status);
  assign wr_status = req.wr && hit(req.addr, pcs_ctl_pkg::off_link_status);

  //////////////////////////////////////////////////////////////////////////////
  pcs_reg_slice #(.reset_value(pcs_ctl_pkg::rst_configuration), .write_mask(pcs_ctl_pkg::cfg_write_mask)) u_cfg (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(req.wr && hit(req.addr, pcs_ctl_pkg::off_configuration)),
    .wdata(req.wdata),
    .hw_clear(32'h0000_0000),
    .value(cfg)
  );

  assign lc_clear = lc[pcs_ctl_pkg::lc_restart_bit] ? (32'h0000_0001 << pcs_ctl_pkg::lc_restart_bit) : 32'h0000_0000;

  pcs_reg_slice #(.reset_value(pcs_ctl_pkg::rst_link_control), .write_mask(pcs_ctl_pkg::lc_write_mask)) u_lc (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(req.wr && hit(req.addr, pcs_ctl_pkg::off_link_control)),
    .wdata(req.wdata),
    .hw_clear(lc_clear),
    .value(lc)
  );

  // half duplex bit excluded from write mask
  pcs_reg_slice #(.reset_value(pcs_ctl_pkg::rst_advertisement), .write_mask(pcs_ctl_pkg::adv_write_mask)) u_adv (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(req.wr && hit(req.addr, pcs_ctl_pkg::off_advertisement)),
    .wdata(req.wdata),
    .hw_clear(32'h0000_0000),
    .value(adv)
  );

  pcs_page_rx u_page (
    .core_clk(core_clk),
    .reset(reset),
    .word_valid(rx_word_valid),
    .word(rx_word),
    .page(page)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_s1_ff <= 1'b0;
      sync_s2_ff <= 1'b0;
      idle_s1_ff <= 1'b0;
      idle_s2_ff <= 1'b0;
      sync_prev_ff <= 1'b0;
    end else begin
      sync_s1_ff <= sync_ok_in;
      sync_s2_ff <= sync_s1_ff;
      idle_s1_ff <= idle_ok_in;
      idle_s2_ff <= idle_s1_ff;
      sync_prev_ff <= sync_s2_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      partner_ff <= 16'h0000;
    end else if (page.valid && state_ff == pcs_ctl_pkg::an_ability) begin
      partner_ff <= page.word & pcs_ctl_pkg::page_mask;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fast timer shortens interval
  assign timer_limit = lc[pcs_ctl_pkg::lc_fast_timer_bit] ? pcs_ctl_pkg::fast_timer_cycles
                                                          : pcs_ctl_pkg::link_timer_cycles;
  // sync loss restarts sgmii only with trigger
  assign restart_req = lc[pcs_ctl_pkg::lc_restart_bit] ||
                       (sync_prev_ff && !sync_s2_ff && (!sgmii_mode || lc[pcs_ctl_pkg::lc_trigger_bit]));
  assign an_start = (state_ff == pcs_ctl_pkg::an_restart);

  always_ff @(posedge core_clk) begin
    if (reset || cfg[pcs_ctl_pkg::cfg_soft_reset_bit]) begin
      state_ff <= pcs_ctl_pkg::an_disabled;
      timer_ff <= 32'h0000_0000;
      page_wait_ff <= 32'h0000_0000;
    end else if (!lc[pcs_ctl_pkg::lc_negotiation_enable_bit] || !cfg[pcs_ctl_pkg::cfg_enable_bit]) begin
      state_ff <= pcs_ctl_pkg::an_disabled;
    end else if (restart_req || state_ff == pcs_ctl_pkg::an_disabled) begin
      state_ff <= pcs_ctl_pkg::an_restart;
      timer_ff <= 32'h0000_0000;
    end else begin
      timer_ff <= timer_ff + 32'h0000_0001;
      case (state_ff)
        pcs_ctl_pkg::an_restart: begin
          if (timer_ff >= timer_limit) begin
            state_ff <= pcs_ctl_pkg::an_ability;
            timer_ff <= 32'h0000_0000;
            page_wait_ff <= 32'h0000_0000;
          end
        end
        pcs_ctl_pkg::an_ability: begin
          page_wait_ff <= page_wait_ff + 32'h0000_0001;
          if (page.valid) begin
            state_ff <= pcs_ctl_pkg::an_ack;
            timer_ff <= 32'h0000_0000;
          end else if (lc[pcs_ctl_pkg::lc_timeout_en_bit] && idle_s2_ff &&
                       page_wait_ff >= pcs_ctl_pkg::timeout_pages_cycles) begin
            state_ff <= pcs_ctl_pkg::an_link_ok;
          end
        end
        pcs_ctl_pkg::an_ack: begin
          if (timer_ff >= timer_limit) begin
            state_ff <= (sgmii_mode && lc[pcs_ctl_pkg::lc_bypass_bit]) ? pcs_ctl_pkg::an_link_ok
                                                                       : pcs_ctl_pkg::an_idle_detect;
            timer_ff <= 32'h0000_0000;
          end
        end
        pcs_ctl_pkg::an_idle_detect: begin
          if (timer_ff >= timer_limit && idle_s2_ff) begin
            state_ff <= pcs_ctl_pkg::an_link_ok;
          end
        end
        pcs_ctl_pkg::an_link_ok: begin
          timer_ff <= 32'h0000_0000;
        end
        default: state_ff <= pcs_ctl_pkg::an_disabled;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign an_link_ok = (state_ff == pcs_ctl_pkg::an_link_ok) && sync_s2_ff;
  // sgmii speed and duplex from phy word
  assign an_speed = sgmii_mode ? partner_ff[pcs_ctl_pkg::lp_sgmii_speed_lo +: 2]
                               : lc[pcs_ctl_pkg::lc_speed_lo +: 2];
  assign an_duplex = sgmii_mode ? partner_ff[pcs_ctl_pkg::lp_sgmii_duplex_bit] : lc[pcs_ctl_pkg::lc_duplex_bit];
  assign link_var = lc[pcs_ctl_pkg::lc_force_link_bit] ? lc[pcs_ctl_pkg::lc_forced_link_bit]
                  : (lc[pcs_ctl_pkg::lc_negotiation_enable_bit] ? an_link_ok : sync_s2_ff);

  // enable gates both directions, isolate cuts mac path
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pcs_tx_enable <= 1'b0;
      pcs_rx_enable <= 1'b0;
      mac_path_enable <= 1'b0;
      soft_reset_ctl <= 1'b0;
      link_ok <= 1'b0;
      link_speed <= pcs_ctl_pkg::rst_forced_speed;
      link_duplex <= 1'b1;
      tx_config_word <= 16'h0000;
      tx_config_send <= 1'b0;
    end else begin
      pcs_tx_enable <= cfg[pcs_ctl_pkg::cfg_enable_bit];
      pcs_rx_enable <= cfg[pcs_ctl_pkg::cfg_enable_bit];
      mac_path_enable <= cfg[pcs_ctl_pkg::cfg_enable_bit] && !cfg[pcs_ctl_pkg::cfg_isolate_bit];
      soft_reset_ctl <= cfg[pcs_ctl_pkg::cfg_soft_reset_bit];
      link_ok <= link_var && cfg[pcs_ctl_pkg::cfg_enable_bit];
      if (lc[pcs_ctl_pkg::lc_force_sd_bit] || !lc[pcs_ctl_pkg::lc_negotiation_enable_bit] || !sgmii_mode) begin
        link_speed <= lc[pcs_ctl_pkg::lc_speed_lo +: 2];
        link_duplex <= lc[pcs_ctl_pkg::lc_duplex_bit];
      end else begin
        link_speed <= an_speed;
        link_duplex <= an_duplex;
      end
      tx_config_word <= adv[15:0] | ((state_ff == pcs_ctl_pkg::an_ack) ? 16'h4000 : 16'h0000);
      tx_config_send <= cfg[pcs_ctl_pkg::cfg_enable_bit] && (state_ff == pcs_ctl_pkg::an_restart ||
                        state_ff == pcs_ctl_pkg::an_ability || state_ff == pcs_ctl_pkg::an_ack);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pause_tx_active <= 1'b0;
      pause_rx_active <= 1'b0;
    end else if (lc[pcs_ctl_pkg::lc_force_fc_bit]) begin
      pause_tx_active <= pause_transmit_enable;
      pause_rx_active <= pause_receive_enable;
    end else begin
      pause_tx_active <= complete_ff && ((adv[7] && partner_ff[7]) || (!adv[7] && adv[8] && partner_ff[7] && partner_ff[8]));
      pause_rx_active <= complete_ff && ((adv[7] && partner_ff[7]) || (adv[7] && adv[8] && !partner_ff[7] && partner_ff[8]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latch a link fall until read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_var_prev_ff <= 1'b0;
      latched_low_ff <= 1'b0;
    end else begin
      link_var_prev_ff <= link_ok;
      if (lc[pcs_ctl_pkg::lc_latch_bit] && link_var_prev_ff && !link_ok) begin
        latched_low_ff <= 1'b1;
      end else if (rd_status || !lc[pcs_ctl_pkg::lc_latch_bit]) begin
        latched_low_ff <= 1'b0;
      end
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      complete_ff <= 1'b0;
      page_flag_ff <= 1'b0;
      timedout_ff <= 1'b0;
      fault_flag_ff <= 1'b0;
      error_ff <= 1'b0;
    end else begin
      if (state_ff == pcs_ctl_pkg::an_link_ok) begin
        complete_ff <= 1'b1;
      end else if (an_start || state_ff == pcs_ctl_pkg::an_disabled) begin
        complete_ff <= 1'b0;
      end
      if (page.valid && state_ff == pcs_ctl_pkg::an_ability) begin
        page_flag_ff <= 1'b1;
      end else if (rd_status) begin
        page_flag_ff <= 1'b0;
      end
      if (page.valid && state_ff == pcs_ctl_pkg::an_ability && !sgmii_mode &&
          page.word[pcs_ctl_pkg::adv_fault_lo +: 2] != 2'h0) begin
        fault_flag_ff <= 1'b1;
      end else if (rd_status) begin
        fault_flag_ff <= 1'b0;
      end
      if (an_start) begin
        timedout_ff <= 1'b0;
      end else if (state_ff == pcs_ctl_pkg::an_ability && !page.valid && lc[pcs_ctl_pkg::lc_timeout_en_bit] &&
                   idle_s2_ff && page_wait_ff >= pcs_ctl_pkg::timeout_pages_cycles) begin
        timedout_ff <= 1'b1;
      end
      if (state_ff == pcs_ctl_pkg::an_link_ok && !complete_ff &&
          (sgmii_mode ? (an_speed == pcs_ctl_pkg::speed_1000 && !an_duplex)
                      : (!adv[pcs_ctl_pkg::adv_fd_bit] || !partner_ff[pcs_ctl_pkg::adv_fd_bit]))) begin
        error_ff <= 1'b1;
      end else if (an_start) begin
        error_ff <= 1'b0;
      end else if (wr_status) begin
        error_ff <= req.wdata[pcs_ctl_pkg::st_error_bit];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status word; partner page fields masked per mode on read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= 32'h0000_0000;
      if (req.rd) begin
        if (hit(req.addr, pcs_ctl_pkg::off_configuration)) begin
          rdata_ff <= cfg;
        end else if (hit(req.addr, pcs_ctl_pkg::off_link_control)) begin
          rdata_ff <= lc;
        end else if (hit(req.addr, pcs_ctl_pkg::off_link_status)) begin
          rdata_ff <= {11'h000, error_ff, fault_flag_ff, timedout_ff, page_flag_ff, complete_ff, 11'h000,
                       sync_s2_ff, link_duplex, link_speed, link_ok && !latched_low_ff};
        end else if (hit(req.addr, pcs_ctl_pkg::off_advertisement)) begin
          rdata_ff <= adv;
        end else if (hit(req.addr, pcs_ctl_pkg::off_partner_ability)) begin
          rdata_ff <= {16'h0000, sgmii_mode ? (partner_ff & 16'h9c00) : (partner_ff & 16'hf1e0)};
        end
      end
    end
  end

  assign reg_rdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  sequence seq_restart_written;
    req.wr && hit(req.addr, pcs_ctl_pkg::off_link_control) && req.wdata[pcs_ctl_pkg::lc_restart_bit];
  endsequence
  sequence seq_restart_cleared;
    lc[pcs_ctl_pkg::lc_restart_bit] ##1 !lc[pcs_ctl_pkg::lc_restart_bit];
  endsequence

  AST_PCS_ENABLE: assert property (@(posedge core_clk) disable iff (reset)
    !cfg[pcs_ctl_pkg::cfg_enable_bit] |=> !pcs_tx_enable && !pcs_rx_enable && !link_ok) else $error("pcs off but active");
  AST_ISOLATE: assert property (@(posedge core_clk) disable iff (reset)
    cfg[pcs_ctl_pkg::cfg_isolate_bit] |=> !mac_path_enable) else $error("isolate ignored");
  AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (reset)
    cfg[pcs_ctl_pkg::cfg_soft_reset_bit] |=> soft_reset_ctl && state_ff == pcs_ctl_pkg::an_disabled) else $error("soft reset lost");
  AST_FORCE_LINK: assert property (@(posedge core_clk) disable iff (reset)
    lc[pcs_ctl_pkg::lc_force_link_bit] && cfg[pcs_ctl_pkg::cfg_enable_bit] |=> link_ok == $past(lc[pcs_ctl_pkg::lc_forced_link_bit])) else $error("forced link wrong");
  AST_FORCE_SPEED: assert property (@(posedge core_clk) disable iff (reset)
    lc[pcs_ctl_pkg::lc_force_sd_bit] |=> link_speed == $past(lc[2:1]) && link_duplex == $past(lc[3])) else $error("forced speed wrong");
  AST_RESTART_SC: assert property (@(posedge core_clk) disable iff (reset)
    seq_restart_written |=> seq_restart_cleared) else $error("restart not self cleared");
  AST_AN_DISABLED: assert property (@(posedge core_clk) disable iff (reset)
    !lc[pcs_ctl_pkg::lc_negotiation_enable_bit] |=> state_ff == pcs_ctl_pkg::an_disabled) else $error("an ran while disabled");
  AST_COMPLETE: assert property (@(posedge core_clk) disable iff (reset)
    state_ff == pcs_ctl_pkg::an_link_ok |=> complete_ff) else $error("complete not set");
  AST_PAGE_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    rd_status && !(page.valid && state_ff == pcs_ctl_pkg::an_ability) |=> !page_flag_ff) else $error("page flag not cleared");
  AST_HALF_DUPLEX: assert property (@(posedge core_clk) disable iff (reset)
    !adv[pcs_ctl_pkg::adv_hd_bit]) else $error("half duplex advertised");
endmodule

// file: testbench/pcs_partner_model.sv
// partner model: link partner that streams one base page and keeps idles valid
module pcs_partner_model (
  input wire logic core_clk,
  input wire logic send,
  input wire logic [15:0] page,
  output logic sync_ok,
  output logic idle_ok,
  output logic word_valid,
  output logic [15:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sync_ok = 1'b1;
    idle_ok = 1'b1;
    word_valid = 1'b0;
    word = 16'h0000;
  end
  // word line toggles while idle with word_valid low, so the capture ignores it and keeps the last page as its repeat reference
  always @(posedge core_clk) begin
    word_valid <= send;
    word <= send ? page : ~word;
  end
endmodule

// file: testbench/pcs_link_autoneg_control_tb.sv
// testbench: register map, forcing controls and partner page capture
module pcs_link_autoneg_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sgmii_mode = 1'b0;
  logic send = 1'b0;
  logic pause_transmit_enable = 1'b0;
  logic pause_receive_enable = 1'b0;
  logic [15:0] page = 16'h21a0;
  logic [31:0] reg_rdata, v;
  logic [15:0] tx_config_word, rx_word;
  logic [1:0] link_speed;
  logic tx_config_send, pcs_tx_enable, pcs_rx_enable, mac_path_enable, soft_reset_ctl, link_ok;
  logic link_duplex, pause_tx_active, pause_rx_active, sync_ok_in, idle_ok_in, rx_word_valid;
  int mismatches = 0;
  int num_checks = 0;
  always #2.5 core_clk = ~core_clk;
  pcs_link_autoneg_control dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sgmii_mode, .sync_ok_in, .idle_ok_in, .rx_word_valid, .rx_word, .pause_transmit_enable,
    .pause_receive_enable, .tx_config_word, .tx_config_send, .pcs_tx_enable, .pcs_rx_enable,
    .mac_path_enable, .soft_reset_ctl, .link_ok, .link_speed, .link_duplex, .pause_tx_active,
    .pause_rx_active);
  pcs_partner_model partner (.core_clk, .send, .page, .sync_ok(sync_ok_in), .idle_ok(idle_ok_in),
    .word_valid(rx_word_valid), .word(rx_word));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(pcs_ctl_pkg::off_configuration, v);
    chk(v, 32'h0000_0008); // enable resets set
    rd(pcs_ctl_pkg::off_link_control, v);
    chk(v, 32'h0204_000c); // speed resets 1000
    rd(16'h4204, v);
    chk(v, 32'h0000_0000);
    chk({30'h0, pcs_tx_enable, pcs_rx_enable}, 32'h0000_0003); // pcs runs
    $display("test reset values done");
  endtask
  task automatic t_cfg;
    wr(pcs_ctl_pkg::off_configuration, 32'hc000_0000);
    chk({30'h0, pcs_tx_enable, pcs_rx_enable}, 32'h0000_0000); // codes stop
    chk({31'h0, mac_path_enable}, 32'h0000_0000); // isolate path
    repeat (40) @(posedge core_clk);
    #1 chk({31'h0, soft_reset_ctl}, 32'h0000_0001); // not self clearing
    wr(pcs_ctl_pkg::off_configuration, 32'h0000_0008);
    chk({29'h0, soft_reset_ctl, mac_path_enable, pcs_tx_enable}, 32'h0000_0003); // cleared by write
    $display("test configuration done");
  endtask
  task automatic t_force;
    pause_transmit_enable <= 1'b1;
    // forced link up, 100 Mb/s half, forced pause
    wr(pcs_ctl_pkg::off_link_control, 32'h0000_00b3);
    chk({30'h0, link_ok, link_duplex}, 32'h0000_0002); // forced values
    chk({30'h0, link_speed}, 32'h0000_0001); // forced speed
    chk({30'h0, pause_tx_active, pause_rx_active}, 32'h0000_0002); // pause from inputs
    rd(pcs_ctl_pkg::off_link_status, v);
    chk(v & 32'h0000_001f, 32'h0000_0013); // live status fields
    wr(pcs_ctl_pkg::off_link_control, 32'h0000_00f3);
    wr(pcs_ctl_pkg::off_link_control, 32'h0000_00f2);
    chk({31'h0, link_ok}, 32'h0000_0000); // forced down
    wr(pcs_ctl_pkg::off_link_control, 32'h0000_00f3);
    rd(pcs_ctl_pkg::off_link_status, v);
    chk(v & 32'h0000_0001, 32'h0000_0000); // fall held until read
    rd(pcs_ctl_pkg::off_link_status, v);
    chk(v & 32'h0000_0001, 32'h0000_0001); // live after read
    $display("test forcing done");
  endtask
  task automatic t_adv;
    wr(pcs_ctl_pkg::off_advertisement, 32'hffff_ffff);
    rd(pcs_ctl_pkg::off_advertisement, v);
    chk(v, 32'h0000_b1a0); // half duplex fixed zero
    wr(pcs_ctl_pkg::off_advertisement, 32'h0000_0020);
    $display("test advertisement done");
  endtask
  task automatic t_page;
    int n;
    // fast timer, poll bound too short for the slow one
    wr(pcs_ctl_pkg::off_link_control, 32'h0103_000c);
    send <= 1'b1;
    n = 0;
    v = 32'h0000_0000;
    while (v[17] !== 1'b1 && n < 400) begin
      rd(pcs_ctl_pkg::off_link_status, v);
      n++;
    end
    if (n >= 400) begin
      mismatches++;
      return;
    end
    chk(v & 32'h000a_0000, 32'h000a_0000); // page and fault flags
    send <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(pcs_ctl_pkg::off_partner_ability, v);
    chk(v, 32'h0000_21a0); // page held
    rd(pcs_ctl_pkg::off_link_status, v);
    chk(v & 32'h000a_0000, 32'h0000_0000); // clear on read
    rd(pcs_ctl_pkg::off_link_control, v);
    chk(v & 32'h0002_0000, 32'h0000_0000); // restart self clears
    repeat (150) @(posedge core_clk);
    #1 chk({15'h0, tx_config_send, tx_config_word}, 32'h0000_0020); // page idle after link
    chk({30'h0, pause_tx_active, pause_rx_active}, 32'h0000_0000); // no pause resolved
    rd(pcs_ctl_pkg::off_link_status, v);
    chk(v & 32'h0015_0011, 32'h0001_0011); // complete, link, sync
    $display("test page capture done");
  endtask
  task automatic t_sgmii;
    int n;
    sgmii_mode <= 1'b1;
    page <= 16'h9400;
    // timeout kept off in sgmii; bypass, fast timer, restart
    wr(pcs_ctl_pkg::off_link_control, 32'h010b_000c);
    send <= 1'b1;
    n = 0;
    v = 32'h0000_0000;
    while (v[17] !== 1'b1 && n < 400) begin
      rd(pcs_ctl_pkg::off_link_status, v);
      n++;
    end
    send <= 1'b0;
    if (n >= 400) begin
      mismatches++;
      return;
    end
    rd(pcs_ctl_pkg::off_partner_ability, v);
    chk(v, 32'h0000_9400); // sgmii fields
    repeat (70) @(posedge core_clk);
    #1 chk({29'h0, link_ok, link_speed}, 32'h0000_0005); // bypass gives early link
    chk({31'h0, link_duplex}, 32'h0000_0001); // phy duplex
    rd(pcs_ctl_pkg::off_link_status, v);
    chk(v & 32'h001b_0000, 32'h0001_0000); // complete, no fault
    sgmii_mode <= 1'b0;
    $display("test sgmii done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_cfg();
    t_force();
    t_adv();
    t_page();
    t_sgmii();
    give_verdict();
  end
endmodule
